/* File: design/cipher_seq_pkg.sv */
// Package of register offsets, fields and modes shared by both ends of the start sequencer.
package cipher_seq_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] MODE_OFS   = 8'h04;
  localparam logic [7:0] IEN_OFS    = 8'h10;
  localparam logic [7:0] IDIS_OFS   = 8'h14;
  localparam logic [7:0] IMASK_OFS  = 8'h18;
  localparam logic [7:0] ISTAT_OFS  = 8'h1C;
  localparam logic [7:0] KEY_OFS    = 8'h20;
  localparam logic [7:0] IN_OFS     = 8'h40;
  localparam logic [7:0] OUT_OFS    = 8'h50;
  localparam logic [7:0] IV_OFS     = 8'h60;
  localparam int unsigned START_BIT = 0;
  localparam int unsigned RESET_BIT = 8;
  localparam int unsigned START_MODE_LSB = 8;
  localparam int unsigned KSIZE_LSB = 10;
  localparam int unsigned CHAIN_MODE_LSB = 12;
  localparam int unsigned CFBS_LSB  = 16;
  localparam int unsigned READY_BIT = 0;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [3:0] PROC_CYCLES = 4'hA;
  typedef enum logic [1:0] {SM_MANUAL = 2'h0, SM_AUTO = 2'h1, SM_DMA = 2'h2} start_mode_t;
  typedef enum logic [2:0] {CM_ECB = 3'h0, CM_CBC = 3'h1, CM_OFB = 3'h2, CM_CFB = 3'h3,
                            CM_CTR = 3'h4} chain_mode_t;
  typedef enum logic [2:0] {FB_128 = 3'h0, FB_64 = 3'h1, FB_32 = 3'h2, FB_16 = 3'h3,
                            FB_8 = 3'h4} cfb_size_t;
  function automatic logic [3:0] required_words(input logic [2:0] op, input logic [2:0] fb);
    if (op != CM_CFB || fb == FB_128) required_words = 4'hF;
    else if (fb == FB_64) required_words = 4'h3;
    else required_words = 4'h1;
  endfunction
endpackage

/* File: design/cipher_bus_if.sv */
// Register bus joining the software/DMA end to the start sequencer.
`timescale 1ns/1ps
interface cipher_bus_if;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        irq;
  logic        dma_req;
  modport device (input wr_en, input rd_en, input addr, input wdata, output rdata, output irq, output dma_req);
  modport host   (output wr_en, output rd_en, output addr, output wdata, input rdata, input irq, input dma_req);
endinterface

/* File: design/cipher_start_sequencer.sv */
// Device end: mode, key, vector, input and output registers and start sequencing.
`timescale 1ns/1ps
module cipher_start_sequencer (
  input  wire logic   clk,
  input  wire logic   rst_b,
  cipher_bus_if.device bus,
  output logic        busy,
  output logic [1:0]  key_len_sel
);
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_RUN = 2'h1, ST_DONE = 2'h2} seq_state_t;
  seq_state_t   state, next_state;
  logic [31:0]  mode, next_mode;
  logic         ien, next_ien;
  logic         ready, next_ready;
  logic [3:0]   written, next_written;
  logic [3:0]   cnt, next_cnt;
  logic [31:0]  in_w [4];
  logic [31:0]  key_w [8];
  logic [31:0]  iv_w [4];
  logic [31:0]  out_w [4];
  logic [31:0]  rdata, next_rdata;
  logic         irq, dma_req, next_dma_req;
  logic [3:0]   need;
  logic         in_wr, out_rd, launch;
  logic [1:0]   widx;

  assign widx   = bus.addr[3:2];
  assign in_wr  = bus.wr_en && bus.addr[7:4] == cipher_seq_pkg::IN_OFS[7:4];
  assign out_rd = bus.rd_en && bus.addr[7:4] == cipher_seq_pkg::OUT_OFS[7:4];
  assign need   = cipher_seq_pkg::required_words(mode[cipher_seq_pkg::CHAIN_MODE_LSB +: 3],
                                                 mode[cipher_seq_pkg::CFBS_LSB +: 3]);

  always_comb begin
    next_mode    = mode;
    next_ien     = ien;
    next_written = written;
    launch       = 1'b0;
    if (bus.wr_en) begin
      if (bus.addr == cipher_seq_pkg::MODE_OFS) begin
        next_mode    = bus.wdata;
        next_written = 4'h0;
      end else if (bus.addr == cipher_seq_pkg::IEN_OFS) begin
        next_ien = ien | bus.wdata[cipher_seq_pkg::READY_BIT];
      end else if (bus.addr == cipher_seq_pkg::IDIS_OFS) begin
        next_ien = ien & ~bus.wdata[cipher_seq_pkg::READY_BIT];
      end else if (in_wr && mode[cipher_seq_pkg::START_MODE_LSB +: 2] == cipher_seq_pkg::SM_DMA) begin
        // Fixed-address feeding always hits word 0, so each write fills the next free slot.
        next_written = written | (written + 4'h1);
      end else if (in_wr) begin
        next_written = written | (4'h1 << widx);
      end
    end
    case (mode[cipher_seq_pkg::START_MODE_LSB +: 2])
      cipher_seq_pkg::SM_MANUAL: launch = bus.wr_en && bus.addr == cipher_seq_pkg::CTRL_OFS &&
                                          bus.wdata[cipher_seq_pkg::START_BIT];
      default: launch = (next_written & need) == need && state == ST_IDLE;
    endcase
    if (launch && state == ST_IDLE) next_written = 4'h0;
  end

  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_ready   = ready;
    next_dma_req = 1'b0;
    case (state)
      ST_IDLE: begin
        if (launch) begin
          next_state = ST_RUN;
          next_cnt   = cipher_seq_pkg::PROC_CYCLES;
        end
      end
      ST_RUN: begin
        next_cnt = cnt - 4'h1;
        if (cnt == 4'h1) next_state = ST_DONE;
      end
      default: next_state = ST_IDLE;
    endcase
    if (out_rd) next_ready = 1'b0;
    if (state == ST_DONE) next_ready = 1'b1;
    if (mode[cipher_seq_pkg::START_MODE_LSB +: 2] == cipher_seq_pkg::SM_DMA && next_state == ST_IDLE &&
        !(state == ST_IDLE && launch)) next_dma_req = 1'b1;
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (bus.addr == cipher_seq_pkg::MODE_OFS) next_rdata = mode;
    else if (bus.addr == cipher_seq_pkg::IMASK_OFS) next_rdata = {31'h0, ien};
    else if (bus.addr == cipher_seq_pkg::ISTAT_OFS) next_rdata = {31'h0, ready};
    else if (bus.addr[7:4] == cipher_seq_pkg::OUT_OFS[7:4]) next_rdata = out_w[widx];
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state   <= ST_IDLE;
      mode    <= cipher_seq_pkg::MODE_RESET;
      ien     <= 1'b0;
      ready   <= 1'b0;
      written <= 4'h0;
      cnt     <= 4'h0;
      rdata   <= 32'h0000_0000;
      irq     <= 1'b0;
      dma_req <= 1'b0;
      busy    <= 1'b0;
    end else begin
      state   <= next_state;
      mode    <= next_mode;
      ien     <= next_ien;
      ready   <= next_ready;
      written <= next_written;
      cnt     <= next_cnt;
      rdata   <= bus.rd_en ? next_rdata : 32'h0000_0000;
      irq     <= next_ready & next_ien;
      dma_req <= next_dma_req;
      busy    <= next_state == ST_RUN;
    end
  end

  // The datapath is outside this block, so output words simply mirror input xor key xor vector.
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_words
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          in_w[g]  <= 32'h0000_0000;
          iv_w[g]  <= 32'h0000_0000;
          out_w[g] <= 32'h0000_0000;
        end else begin
          if (in_wr && widx == g) in_w[g] <= bus.wdata;
          if (bus.wr_en && bus.addr == cipher_seq_pkg::IV_OFS + 8'(4 * g)) iv_w[g] <= bus.wdata;
          if (state == ST_DONE) out_w[g] <= in_w[g] ^ key_w[g] ^ iv_w[g];
        end
      end
    end
    // key words up to 256 bits
    for (g = 0; g < 8; g++) begin : g_key
      always_ff @(posedge clk) begin
        if (!rst_b) key_w[g] <= 32'h0000_0000;
        else if (bus.wr_en && bus.addr == cipher_seq_pkg::KEY_OFS + 8'(4 * g)) key_w[g] <= bus.wdata;
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_b) key_len_sel <= 2'h0;
    else key_len_sel <= mode[cipher_seq_pkg::KSIZE_LSB +: 2];
  end

  assign bus.rdata   = rdata;
  assign bus.irq     = irq;
  assign bus.dma_req = dma_req;
endmodule // cipher_start_sequencer

/* File: design/cipher_host_end.sv */
// Host end: software setup sequence and DMA feeding of input word 0.
`timescale 1ns/1ps
module cipher_host_end (
  input  wire logic   clk,
  input  wire logic   rst_b,
  cipher_bus_if.host  bus,
  input  wire logic   go,
  input  wire logic [31:0] mode_word,
  input  wire logic   want_irq,
  input  wire logic [31:0] data_word,
  output logic        done,
  output logic [31:0] result
);
  typedef enum logic [2:0] {H_IDLE = 3'h0, H_MODE = 3'h1, H_KEY = 3'h2, H_IV = 3'h3, H_IEN = 3'h4,
                            H_DATA = 3'h5, H_START = 3'h6, H_WAIT = 3'h7} host_state_t;
  host_state_t state, next_state;
  logic [3:0]  idx, next_idx;
  logic        wr_en, next_wr_en, rd_en, next_rd_en, next_done;
  logic [7:0]  addr, next_addr;
  logic [31:0] wdata, next_wdata, next_result;
  logic [3:0]  need;
  logic [1:0]  start_sel;

  assign start_sel = mode_word[cipher_seq_pkg::START_MODE_LSB +: 2];
  assign need = cipher_seq_pkg::required_words(mode_word[cipher_seq_pkg::CHAIN_MODE_LSB +: 3],
                                               mode_word[cipher_seq_pkg::CFBS_LSB +: 3]);

  always_comb begin
    next_state = state;
    next_idx   = idx;
    next_wr_en = 1'b0;
    next_rd_en = 1'b0;
    next_addr  = addr;
    next_wdata = wdata;
    next_done  = 1'b0;
    next_result = result;
    case (state)
      H_IDLE: if (go) begin
        next_state = H_KEY;
        next_wr_en = 1'b1;
        next_addr  = cipher_seq_pkg::MODE_OFS;
        next_wdata = mode_word;
        next_idx   = 4'h0;
      end
      H_KEY: begin
        next_wr_en = 1'b1;
        next_addr  = cipher_seq_pkg::KEY_OFS + {2'h0, idx[3:0], 2'h0};
        next_wdata = data_word;
        next_idx   = idx + 4'h1;
        if (idx == 4'h7) begin
          next_idx   = 4'h0;
          next_state = mode_word[cipher_seq_pkg::CHAIN_MODE_LSB +: 3] == cipher_seq_pkg::CM_ECB ? H_IEN : H_IV;
        end
      end
      H_IV: begin
        next_wr_en = 1'b1;
        next_addr  = cipher_seq_pkg::IV_OFS + {2'h0, idx[3:0], 2'h0};
        next_wdata = data_word;
        next_idx   = idx + 4'h1;
        if (idx == 4'h3) begin
          next_idx   = 4'h0;
          next_state = H_IEN;
        end
      end
      H_IEN: begin
        next_wr_en = 1'b1;
        next_addr  = want_irq ? cipher_seq_pkg::IEN_OFS : cipher_seq_pkg::IDIS_OFS;
        next_wdata = 32'h0000_0001;
        next_state = H_DATA;
      end
      H_DATA: begin
        next_wr_en = need[idx[1:0]];
        next_wdata = data_word;
        next_addr  = start_sel == cipher_seq_pkg::SM_DMA ? cipher_seq_pkg::IN_OFS
                                                    : cipher_seq_pkg::IN_OFS + {4'h0, idx[1:0], 2'h0};
        next_idx   = idx + 4'h1;
        if (idx == 4'h3) begin
          next_idx   = 4'h0;
          next_state = start_sel == cipher_seq_pkg::SM_MANUAL ? H_START : H_WAIT;
        end
      end
      H_START: begin
        next_wr_en = 1'b1;
        next_addr  = cipher_seq_pkg::CTRL_OFS;
        next_wdata = 32'h0000_0001;
        next_state = H_WAIT;
      end
      default: begin
        next_addr  = cipher_seq_pkg::OUT_OFS;
        if (idx == 4'h0 && bus.irq | !want_irq) begin
          next_rd_en = 1'b1;
          next_idx   = 4'h1;
        end else if (idx == 4'h1) begin
          next_idx = 4'h2;
        end else if (idx == 4'h2) begin
          next_result = bus.rdata;
          next_done   = 1'b1;
          next_idx    = 4'h0;
          next_state  = H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state  <= H_IDLE;
      idx    <= 4'h0;
      wr_en  <= 1'b0;
      rd_en  <= 1'b0;
      addr   <= 8'h00;
      wdata  <= 32'h0000_0000;
      done   <= 1'b0;
      result <= 32'h0000_0000;
    end else begin
      state  <= next_state;
      idx    <= next_idx;
      wr_en  <= next_wr_en;
      rd_en  <= next_rd_en;
      addr   <= next_addr;
      wdata  <= next_wdata;
      done   <= next_done;
      result <= next_result;
    end
  end

  assign bus.wr_en = wr_en;
  assign bus.rd_en = rd_en;
  assign bus.addr  = addr;
  assign bus.wdata = wdata;
endmodule // cipher_host_end

/* File: test/cipher_seq_properties.sv */
// Assertions on the register bus joining the two ends of the start sequencer.
`timescale 1ns/1ps
module cipher_seq_properties (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic        irq,
  input wire logic        dma_req,
  input wire logic        busy
);
  logic [1:0] start_sel;
  logic [2:0] op;
  logic [2:0] fb;
  logic       ien;
  logic       start_q;
  logic [3:0] seen;
  logic [3:0] req;
  logic [3:0] nxt;
  logic       in_wr;
  assign in_wr = wr_en && addr[7:4] == 4'h4;
  assign nxt   = seen | (in_wr ? 4'h1 << addr[3:2] : 4'h0);
  assign req   = (op != 3'h3 || fb == 3'h0) ? 4'hF : (fb == 3'h1 ? 4'h3 : 4'h1);
  // Helper copy of the mode and enable state, kept apart from the design on purpose.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      start_sel <= 2'h0;
      op      <= 3'h0;
      fb      <= 3'h0;
      ien     <= 1'b0;
      start_q <= 1'b0;
      seen    <= 4'h0;
    end else begin
      start_q <= wr_en && addr == 8'h00 && wdata[0];
      seen    <= (busy || (wr_en && addr == 8'h04)) ? 4'h0 : nxt;
      if (wr_en && addr == 8'h04) begin
        start_sel <= wdata[9:8];
        op   <= wdata[14:12];
        fb   <= wdata[18:16];
      end
      if (wr_en && addr == 8'h10 && wdata[0]) ien <= 1'b1;
      else if (wr_en && addr == 8'h14 && wdata[0]) ien <= 1'b0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_manual_run: assert property (
    wr_en && addr == 8'h00 && wdata[0] && !busy && start_sel == 2'h0
    |=> busy [*8] ##1 busy ##1 busy ##1 !busy) else $error("manual start did not run ten cycles");
  a_no_self_start: assert property ($rose(busy) && start_sel == 2'h0 |-> start_q)
    else $error("manual launch without start write");
  a_auto_launch: assert property (
    in_wr && start_sel == 2'h1 && !busy && (nxt & req) == req |=> busy) else $error("auto launch missing");
  a_launch_cause: assert property ($rose(busy) && start_sel != 2'h0 |-> $past(in_wr))
    else $error("launch without input word write");
  a_ready_irq: assert property ($fell(busy) && ien |=> irq)
    else $error("no interrupt at completion");
  a_irq_enabled: assert property (irq |-> ien || $past(ien))
    else $error("interrupt while disabled");
  a_read_clears: assert property (rd_en && addr[7:4] == 4'h5 && !busy |-> ##2 !irq)
    else $error("output read left flag set");
  a_dma_request: assert property (dma_req |-> start_sel == 2'h2 || $past(start_sel) == 2'h2)
    else $error("transfer request outside dma mode");
endmodule // cipher_seq_properties

/* File: test/cipher_start_sequencer_tb.sv */
// Self-checking bench driving the host end against the device end.
`timescale 1ns/1ps
module cipher_start_sequencer_tb;
  logic        clk;
  logic        rst_b;
  logic        go;
  logic [31:0] mode_word;
  logic        want_irq;
  logic [31:0] data_word;
  logic        done;
  logic [31:0] result;
  logic        busy;
  logic [1:0]  key_len_sel;
  logic [31:0] seed;
  logic [31:0] iv_m;
  logic        saw_irq;
  int          num_errors;
  int          n_tests;
  int          busy_cnt;
  int          in_cnt;
  int          in_off;
  int          t_sm [12] = '{0, 0, 1, 1, 1, 1, 1, 1, 2, 2, 1, 0};
  int          t_op [12] = '{1, 0, 2, 3, 3, 3, 3, 4, 1, 3, 0, 4};
  int          t_fb [12] = '{0, 0, 0, 1, 2, 3, 4, 0, 0, 0, 0, 0};
  int          t_wi [12] = '{1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 0};
  cipher_bus_if bus ();
  cipher_start_sequencer u_cipher_start_sequencer (.clk(clk), .rst_b(rst_b), .bus(bus), .busy(busy),
    .key_len_sel(key_len_sel));
  cipher_host_end u_cipher_host_end (.clk(clk), .rst_b(rst_b), .bus(bus), .go(go), .mode_word(mode_word),
    .want_irq(want_irq), .data_word(data_word), .done(done), .result(result));
  cipher_seq_properties u_cipher_seq_properties (.clk(clk), .rst_b(rst_b), .wr_en(bus.wr_en), .rd_en(bus.rd_en),
    .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata), .irq(bus.irq), .dma_req(bus.dma_req), .busy(busy));
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    xorshift = y ^ (y << 5);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (num_errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Every input word written and every busy cycle is counted per run.
  always @(posedge clk) begin
    if (busy === 1'b1) busy_cnt++;
    if (bus.irq === 1'b1) saw_irq = 1'b1;
    if (bus.wr_en === 1'b1 && bus.addr[7:4] === 4'h4) begin
      in_cnt++;
      if (bus.addr !== 8'h40) in_off++;
    end
  end
  // Key and input carry the same word, as does the vector outside codebook mode, so the result reduces to the earlier vector in codebook mode.
  task automatic run(input int i);
    int k;
    int nreq;
    logic [31:0] exp;
    nreq = (t_op[i] != 3 || t_fb[i] == 0) ? 4 : (t_fb[i] == 1 ? 2 : 1);
    seed = xorshift(seed);
    exp = (t_op[i] == 0) ? iv_m : seed;
    if (t_op[i] != 0) iv_m = seed;
    busy_cnt = 0;
    in_cnt = 0;
    in_off = 0;
    saw_irq = 1'b0;
    @(posedge clk);
    mode_word <= 32'((t_fb[i] << 16) | (t_op[i] << 12) | ((i % 3) << 10) | (t_sm[i] << 8));
    want_irq <= 1'(t_wi[i]);
    data_word <= seed;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (k = 0; k < 300 && done !== 1'b1; k++) @(negedge clk);
    if (k == 300) begin
      check(32'h0, 32'h1);
      final_report();
    end
    if (t_wi[i] != 0) check(result, exp);
    repeat (14) @(posedge clk);
    @(negedge clk);
    check(32'(key_len_sel), 32'(i % 3));
    check(32'(busy_cnt), 32'hA);
    check(32'(saw_irq), 32'(t_wi[i]));
    check(32'(bus.irq), 32'h0);
    if (t_sm[i] == 2) check(32'(in_off), 32'h0);
    else check(32'(in_cnt), 32'(nreq));
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    rst_b = 1'b0;
    go = 1'b0;
    mode_word = 32'h0;
    want_irq = 1'b0;
    data_word = 32'h0;
    seed = 32'h0000DEB1;
    iv_m = 32'h0;
    num_errors = 0;
    n_tests = 0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 12; i++) run(i);
    final_report();
  end
endmodule // cipher_start_sequencer_tb
